// ==== pkg/bsfs_pkg.sv ====
// package: constants for the buck start-up and fault sequencer
package bsfs_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] DUTY_OFS   = 4'h8;
  // control register bit positions
  localparam int CTRL_PWM_EN_BIT = 0;
  localparam int CTRL_OT_CLR_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // steady-state low-side duty (per switching period, in clock cycles)
  localparam logic [7:0] DUTY_RESET  = 8'h80;
  // pre-bias ramp pulse counts per step
  localparam logic [5:0] RAMP_STEP1_PULSES = 6'h20;
  localparam logic [5:0] RAMP_STEP2_PULSES = 6'h10;
  localparam logic [5:0] RAMP_STEP3_PULSES = 6'h08;
  // timing counts in switching cycles
  localparam int HICCUP_CYCLES = 4096;
  localparam int PGOOD_CYCLES  = 256;
  // blanking after low-side rise
  localparam int CLK_MHZ         = 50;
  localparam int BLANK_NS        = 160;
  localparam int BLANK_CYCLES    = (BLANK_NS * CLK_MHZ + 999) / 1000;
  // sequencer states
  typedef enum logic [2:0] {
    BSFS_OFF, BSFS_SOFTSTART, BSFS_RUN, BSFS_HICCUP, BSFS_OVER_TEMP,
    BSFS_OV_ACTIVE, BSFS_OV_LATCHED
  } bsfs_state_e;
endpackage : bsfs_pkg

// ==== rtl/bsfs_sequencer.sv ====
// design: start-up, protection and power-good sequencer for a buck stage
// What this block does
// - drivers off while bias or enable lockout, except the low side stays on while in overvoltage
// - low-side held off until first high pulse
// - low-side ramps quarter, half, three-quarter, full
// - 32, 16, 8 pulses per ramp step
// - soft-start released only on power-on-ready
// - overcurrent stays armed during soft-start
// - enable low tristates both drivers
// - soft-start pin low shuts down output
// - overcurrent trip latches flag, enters hiccup
// - hiccup grounds soft-start for 4096 cycles
// - hiccup repeats while overload persists
// - overcurrent ignored for 160 ns starting one clock after low-side rise
// - over-temperature turns off switches, discharges soft-start
// - over-temperature clear restarts through soft-start
// - power-good released only while in window
// - power-good waits for soft-start delay threshold
// - power-good delayed 256 cycles after window entry
// - overvoltage forces high off, low on
// - after overvoltage latch off until power-on-ready cycles
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
module bsfs_sequencer
  import bsfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // comparator inputs
  input  wire logic        sw_tick_i,
  input  wire logic        bias_ok_i,
  input  wire logic        enable_ok_i,
  input  wire logic        enable_stop_i,
  input  wire logic        ss_shutdown_i,
  input  wire logic        ss_done_i,
  input  wire logic        ss_delay_ok_i,
  input  wire logic        overcurrent_trip_i,
  input  wire logic        overvoltage_trip_i,
  input  wire logic        over_temp_i,
  input  wire logic        sense_in_window_i,
  input  wire logic        pwm_high_i,
  // driver and pin outputs
  output logic             hs_gate_o,
  output logic             hs_gate_oe_o,
  output logic             ls_gate_o,
  output logic             ls_gate_oe_o,
  output logic             ss_discharge_o,
  output logic             pgood_o,
  output logic             pgood_oe_o
);

  bsfs_state_e state;
  bsfs_state_e next_state;
  logic        por;
  logic        por_d;
  logic        oc_flag;
  logic        oc_seen;
  logic [11:0] hiccup_cnt;
  logic [8:0]  pg_cnt;
  logic        pg_ok;
  logic        first_high;
  logic [1:0]  ramp_step;
  logic [5:0]  ramp_cnt;
  logic [7:0]  tick_cnt;
  logic [7:0]  ls_width;
  logic        ls_raw;
  logic        ls_raw_d;
  logic [3:0]  blank_cnt;
  logic        pwm_en;
  logic [7:0]  duty;
  logic        ot_sticky;
  logic        wb_req;
  logic        fault_state;

  // power-on-ready from both monitors
  assign por    = bias_ok_i && enable_ok_i;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // pulse width scaling: step 0..3 gives quarter..full of duty
  function automatic logic [7:0] ramp_width(input logic [1:0] step,
                                            input logic [7:0] d);
    logic [9:0] prod;
    prod = {2'b00, d} * ({8'h00, step} + 10'h001);
    ramp_width = prod[9:2];
  endfunction : ramp_width

  // wishbone register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_en <= CTRL_RESET[CTRL_PWM_EN_BIT];
      duty   <= DUTY_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == CTRL_OFS) begin
        pwm_en <= wb_dat_i[CTRL_PWM_EN_BIT];
      end else if (wb_adr_i == DUTY_OFS) begin
        duty <= wb_dat_i[7:0];
      end
    end
  end

  // over-temp sticky record; hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ot_sticky <= 1'b0;
    end else if (over_temp_i) begin
      ot_sticky <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS
                 && wb_dat_i[CTRL_OT_CLR_BIT]) begin
      ot_sticky <= 1'b0;
    end
  end

  // wishbone answer: one wait-free ack, err on unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      if (wb_req && !wb_err_o) begin
        if (wb_adr_i == CTRL_OFS) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {30'h0, 1'b0, pwm_en};
        end else if (wb_adr_i == STATUS_OFS) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {21'h0, ot_sticky, pgood_oe_o, oc_flag,
                       first_high, ramp_step, 3'(state), por, 1'b0};
        end else if (wb_adr_i == DUTY_OFS) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {24'h0, duty};
        end else begin
          wb_err_o <= 1'b1;
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // next-state logic; overvoltage outranks all restart paths
  always_comb begin
    next_state = state;
    case (state)
      BSFS_OFF: begin
        if (por && overvoltage_trip_i) begin
          next_state = BSFS_OV_ACTIVE;
        end else if (por && !ss_shutdown_i && !over_temp_i) begin
          next_state = BSFS_SOFTSTART;
        end
      end
      BSFS_SOFTSTART, BSFS_RUN: begin
        if (overvoltage_trip_i) begin
          next_state = BSFS_OV_ACTIVE;
        end else if (!por || ss_shutdown_i) begin
          next_state = BSFS_OFF;
        end else if (over_temp_i) begin
          next_state = BSFS_OVER_TEMP;
        end else if (oc_seen) begin
          next_state = BSFS_HICCUP;
        end else if (state == BSFS_SOFTSTART && ss_done_i) begin
          next_state = BSFS_RUN;
        end
      end
      BSFS_HICCUP: begin
        if (overvoltage_trip_i) begin
          next_state = BSFS_OV_ACTIVE;
        end else if (!por) begin
          next_state = BSFS_OFF;
        end else if (sw_tick_i && hiccup_cnt == 12'(HICCUP_CYCLES - 1)) begin
          next_state = BSFS_SOFTSTART;
        end
      end
      BSFS_OVER_TEMP: begin
        if (overvoltage_trip_i) begin
          next_state = BSFS_OV_ACTIVE;
        end else if (!over_temp_i) begin
          next_state = BSFS_OFF;
        end
      end
      BSFS_OV_ACTIVE: begin
        if (!overvoltage_trip_i) begin
          next_state = BSFS_OV_LATCHED;
        end
      end
      BSFS_OV_LATCHED: begin
        if (!por) begin
          next_state = BSFS_OFF;
        end
      end
      default: next_state = BSFS_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= BSFS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // overcurrent flag latched on unblanked trip, cleared after hiccup
  assign oc_seen = overcurrent_trip_i && ls_gate_o && blank_cnt == 4'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_flag <= 1'b0;
    end else if (oc_seen && (state == BSFS_SOFTSTART || state == BSFS_RUN)) begin
      oc_flag <= 1'b1;
    end else if (state == BSFS_HICCUP && next_state != BSFS_HICCUP) begin
      oc_flag <= 1'b0;
    end
  end

  // hiccup counts switching cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || state != BSFS_HICCUP) begin
      hiccup_cnt <= 12'h000;
    end else if (sw_tick_i) begin
      hiccup_cnt <= hiccup_cnt + 12'h001;
    end
  end

  // blanking window after low-side rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_raw_d  <= 1'b0;
      blank_cnt <= 4'h0;
    end else begin
      ls_raw_d <= ls_gate_o;
      if (ls_gate_o && !ls_raw_d) begin
        blank_cnt <= 4'(BLANK_CYCLES);
      end else if (blank_cnt != 4'h0) begin
        blank_cnt <= blank_cnt - 4'h1;
      end
    end
  end

  // pre-bias: first high pulse, then stepped low-side ramp
  always_ff @(posedge clk_i) begin
    if (rst_i || !(state == BSFS_SOFTSTART || state == BSFS_RUN)) begin
      first_high <= 1'b0;
      ramp_step  <= 2'h0;
      ramp_cnt   <= 6'h00;
    end else begin
      if (pwm_high_i && pwm_en) begin
        first_high <= 1'b1;
      end
      if (first_high && sw_tick_i && ramp_step != 2'h3) begin
        if (ramp_cnt == pulses_for(ramp_step) - 6'h01) begin
          ramp_step <= ramp_step + 2'h1;
          ramp_cnt  <= 6'h00;
        end else begin
          ramp_cnt <= ramp_cnt + 6'h01;
        end
      end
    end
  end

  // pulses issued at each ramp step
  function automatic logic [5:0] pulses_for(input logic [1:0] step);
    if (step == 2'h0) begin
      pulses_for = RAMP_STEP1_PULSES;
    end else if (step == 2'h1) begin
      pulses_for = RAMP_STEP2_PULSES;
    end else begin
      pulses_for = RAMP_STEP3_PULSES;
    end
  endfunction : pulses_for

  // low-side on-time counter inside each switching period
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_tick_i) begin
      tick_cnt <= 8'h00;
    end else if (tick_cnt != 8'hFF) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  assign ls_width = ramp_width(ramp_step, duty);
  assign ls_raw   = first_high && !pwm_high_i && (tick_cnt < ls_width);

  // driver outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_gate_o      <= 1'b0;
      ls_gate_o      <= 1'b0;
      hs_gate_oe_o   <= 1'b1;
      ls_gate_oe_o   <= 1'b1;
      ss_discharge_o <= 1'b1;
    end else begin
      hs_gate_oe_o   <= !enable_stop_i;
      ls_gate_oe_o   <= !enable_stop_i;
      ss_discharge_o <= !(next_state == BSFS_SOFTSTART ||
                          next_state == BSFS_RUN);
      case (next_state)
        BSFS_SOFTSTART, BSFS_RUN: begin
          hs_gate_o <= pwm_high_i && pwm_en;
          ls_gate_o <= ls_raw && pwm_en;
        end
        BSFS_OV_ACTIVE: begin
          hs_gate_o <= 1'b0;
          ls_gate_o <= 1'b1;
        end
        default: begin
          hs_gate_o <= 1'b0;
          ls_gate_o <= 1'b0;
        end
      endcase
    end
  end

  // power-good window delay counter
  assign fault_state = !(state == BSFS_SOFTSTART || state == BSFS_RUN);
  always_ff @(posedge clk_i) begin
    if (rst_i || !sense_in_window_i || fault_state) begin
      pg_cnt <= 9'h000;
    end else if (sw_tick_i && pg_cnt != 9'(PGOOD_CYCLES)) begin
      pg_cnt <= pg_cnt + 9'h001;
    end
  end
  assign pg_ok = pg_cnt == 9'(PGOOD_CYCLES) && ss_delay_ok_i;

  // open-drain flag: released only when good, else pulled low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pgood_oe_o <= 1'b1;
    end else begin
      pgood_oe_o <= !(pg_ok && sense_in_window_i && !fault_state);
    end
  end
  assign pgood_o = 1'b0;

endmodule : bsfs_sequencer

// ==== bench/bsfs_partner.sv ====
// far side: tick source, pwm request, soft-start cap, power-good pull-up
module bsfs_partner #(
  parameter int SS_DLY = 60,
  parameter int SS_TOP = 90
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ss_discharge_i,
  input  wire logic pgood_i,
  input  wire logic pgood_oe_i,
  output logic      sw_tick_o,
  output logic      pwm_high_o,
  output logic      ss_done_o,
  output logic      ss_delay_ok_o,
  output logic      pgood_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph;
  int         lvl;
  // sixteen-clock period lets blanking expire while the low side conducts
  always_ff @(posedge clk_i) begin
    ph <= rst_i ? 4'h0 : ph + 4'h1;
  end
  // cap charges only while released; ramp is linear
  always_ff @(posedge clk_i) begin
    if (rst_i || ss_discharge_i) lvl <= 0;
    else if (lvl < SS_TOP) lvl <= lvl + 1;
  end
  // tick every clock while the cap is shorted keeps hiccup runs short
  assign sw_tick_o = ss_discharge_i || (ph == 4'hF);
  assign pwm_high_o = (ph == 4'h0);
  assign ss_done_o = (lvl >= SS_TOP);
  assign ss_delay_ok_o = (lvl >= SS_DLY);
  // external pull-up makes a released flag read high
  assign pgood_wire_o = pgood_oe_i ? pgood_i : 1'b1;
endmodule : bsfs_partner

// ==== bench/bsfs_checker.sv ====
// checker: port-level properties of the sequencer
module bsfs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic bias_ok_i,
  input wire logic enable_ok_i,
  input wire logic enable_stop_i,
  input wire logic ss_shutdown_i,
  input wire logic ss_delay_ok_i,
  input wire logic overvoltage_trip_i,
  input wire logic over_temp_i,
  input wire logic sense_in_window_i,
  input wire logic hs_gate_o,
  input wire logic ls_gate_o,
  input wire logic hs_gate_oe_o,
  input wire logic ls_gate_oe_o,
  input wire logic ss_discharge_o,
  input wire logic pgood_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_lockout_off: assert property (
    !(bias_ok_i && enable_ok_i) |=> !hs_gate_o && !ls_gate_o)
    else $error("gate on during lockout");
  chk_stop_tristate: assert property (
    enable_stop_i |=> !hs_gate_oe_o && !ls_gate_oe_o)
    else $error("driver enabled after stop");
  chk_ss_shutdown: assert property (
    ss_shutdown_i |=> !hs_gate_o && !ls_gate_o)
    else $error("gate on during shutdown");
  chk_hot_off: assert property (
    over_temp_i |=> !hs_gate_o && !ls_gate_o && ss_discharge_o)
    else $error("over-temperature not handled");
  chk_ov_high_off: assert property (
    overvoltage_trip_i |=> !hs_gate_o)
    else $error("high side on in overvoltage");
  chk_window_exit: assert property (
    !sense_in_window_i |=> pgood_oe_o)
    else $error("flag released out of window");
  chk_pgood_cause: assert property (
    $fell(pgood_oe_o) |-> $past(sense_in_window_i) && $past(ss_delay_ok_i))
    else $error("flag released without cause");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_bus_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("bus request not answered");
endmodule : bsfs_checker

bind bsfs_sequencer bsfs_checker i_chk (.*);

// ==== bench/testbench.sv ====
// testbench: sequencer scenarios against a small reference model
module testbench;
  import bsfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
  logic wb_ack_o, wb_err_o, sw_tick_i, ss_done_i, ss_delay_ok_i, e;
  logic pwm_high_i, bias_ok_i = 0, enable_ok_i = 0, enable_stop_i = 0;
  logic ss_shutdown_i = 0, overcurrent_trip_i = 0, overvoltage_trip_i = 0;
  logic over_temp_i = 0, sense_in_window_i = 0, skip_ls = 0, seen_hs = 0;
  logic hs_gate_o, hs_gate_oe_o, ls_gate_o, ls_gate_oe_o, ss_discharge_o;
  logic pgood_o, pgood_oe_o, pg_wire;
  int err_total = 0, compares = 0, cyc = 0, n, t;
  int model [int];
  integer seed = 32'h5870a359;
  bsfs_sequencer i_dut (.*);
  bsfs_partner i_far (.clk_i, .rst_i, .ss_discharge_i(ss_discharge_o),
    .pgood_i(pgood_o), .pgood_oe_i(pgood_oe_o), .sw_tick_o(sw_tick_i),
    .pwm_high_o(pwm_high_i), .ss_done_o(ss_done_i),
    .ss_delay_ok_o(ss_delay_ok_i), .pgood_wire_o(pg_wire));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wrap_up();
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // one classic cycle; the answer edge is the only sampling point
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask : wb
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk(s, v);
  endtask : wait_for
  // ticks seen while a level holds, as the design counts them
  task automatic count_ticks(ref logic s, input logic v);
    t = 0;
    n = 0;
    while (s === v && n < 20000) begin
      @(posedge clk_i);
      n++;
      t += sw_tick_i;
    end
  endtask : count_ticks
  task step(input int k);
    repeat (k) @(posedge clk_i);
  endtask : step
  // hang guard and low-side-before-high monitor
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
    if (rst_i || ss_discharge_o) seen_hs <= 0;
    else if (hs_gate_o) seen_hs <= 1;
    if (ls_gate_o === 1'b1 && !skip_ls && !rst_i) chk(seen_hs, 1);
  end
  initial begin
    step(3);
    rst_i <= 0;
    model[CTRL_OFS] = CTRL_RESET;
    model[DUTY_OFS] = DUTY_RESET;
    wb(0, CTRL_OFS, 0);
    chk(q, model[CTRL_OFS]);
    wb(0, DUTY_OFS, 0);
    chk(q, model[DUTY_OFS]);
    wb(0, 4'hC, 0);
    chk(e, 1);
    r = $random(seed);
    r[7] = 1'b1; // low-side pulse must outlast the blanking window
    wb(1, DUTY_OFS, r);
    model[DUTY_OFS] = r & 32'hFF;
    wb(0, DUTY_OFS, 0);
    chk(q, model[DUTY_OFS]);
    bias_ok_i <= 1;
    step(4);
    chk({hs_gate_o, ls_gate_o, ss_discharge_o}, 3'b001);
    enable_ok_i <= 1;
    wait_for(ss_discharge_o, 0);
    wait_for(ss_delay_ok_i, 1);
    sense_in_window_i <= 1;
    count_ticks(pgood_oe_o, 1);
    chk(t >= 255 && t <= 257, 1);
    chk(pg_wire, 1);
    sense_in_window_i <= 0;
    step(2);
    chk(pg_wire, 0);
    sense_in_window_i <= 1;
    overcurrent_trip_i <= 1;
    wait_for(ss_discharge_o, 1);
    overcurrent_trip_i <= 0;
    count_ticks(ss_discharge_o, 1);
    chk(t >= 4095 && t <= 4097, 1);
    overcurrent_trip_i <= 1;
    wait_for(ss_discharge_o, 1);
    overcurrent_trip_i <= 0;
    wait_for(ss_discharge_o, 0);
    over_temp_i <= 1;
    step(2);
    chk({hs_gate_o, ls_gate_o, ss_discharge_o}, 3'b001);
    over_temp_i <= 0;
    wait_for(ss_discharge_o, 0);
    enable_stop_i <= 1;
    step(2);
    chk({hs_gate_oe_o, ls_gate_oe_o}, 2'b00);
    enable_stop_i <= 0;
    ss_shutdown_i <= 1;
    step(2);
    chk({hs_gate_o, ls_gate_o}, 2'b00);
    ss_shutdown_i <= 0;
    skip_ls <= 1;
    overvoltage_trip_i <= 1;
    step(2);
    chk({hs_gate_o, ls_gate_o}, 2'b01);
    overvoltage_trip_i <= 0;
    over_temp_i <= 1;
    step(2);
    over_temp_i <= 0;
    step(30 + r[4:0]);
    chk({hs_gate_o, ls_gate_o}, 2'b00);
    enable_ok_i <= 0;
    step(2);
    enable_ok_i <= 1;
    wait_for(ss_discharge_o, 0);
    skip_ls <= 0;
    step(4);
    wrap_up();
  end
endmodule : testbench
